// File: lcpa_pkg.sv
package lcpa_pkg;
  localparam int ADDR_W = 8;
  localparam int KEY_W = 40;
  localparam int SES_W = 64;
  localparam int RSP_W = 16;
  localparam int KEY_ONES = 20;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_SEED = 8'h08;
  localparam logic [7:0] OFS_SES_LO = 8'h0C;
  localparam logic [7:0] OFS_SES_HI = 8'h10;
  localparam logic [7:0] OFS_TXK_LO = 8'h14;
  localparam logic [7:0] OFS_TXK_HI = 8'h18;
  localparam logic [7:0] OFS_RXK_LO = 8'h1C;
  localparam logic [7:0] OFS_RXK_HI = 8'h20;
  localparam logic [7:0] OFS_TX_RSP = 8'h24;
  localparam logic [7:0] OFS_CMP = 8'h28;
  localparam logic [7:0] OFS_RCTL = 8'h2C;
  localparam logic [7:0] OFS_RIK_LO = 8'h30;
  localparam logic [7:0] OFS_RIK_HI = 8'h34;
  localparam logic [7:0] OFS_RX_RSP = 8'h38;
  localparam logic [7:0] OFS_RIS_LO = 8'h3C;
  localparam logic [7:0] OFS_RIS_HI = 8'h40;
  // Serializer control bits
  localparam int CTRL_SERIAL_LINK_ENABLE = 0;
  localparam int CTRL_AUTO_START_SELECT = 1;
  localparam int CTRL_FVID = 2;
  localparam int CTRL_FAUD = 3;
  localparam int CTRL_START = 4;
  localparam int CTRL_ENC = 5;
  localparam int CTRL_PRST = 6;
  // Serializer status bits
  localparam int STAT_LOCK = 0;
  localparam int STAT_FSEEN = 1;
  localparam int STAT_BADKEY = 2;
  localparam int STAT_MATCH = 3;
  localparam int STAT_CRYPT = 4;
  localparam int STAT_REP = 5;
  localparam int STAT_LINK = 6;
  localparam int STAT_STATE = 8;
  // Receiver control bits
  localparam int RCTL_DEC = 0;
  localparam int RCTL_SEL0 = 1;
  localparam int RCTL_SEL1 = 2;
  localparam int RCTL_BEGAN = 3;
  localparam int RCTL_NEWDEV = 4;
  localparam int RCTL_REP = 5;
  localparam int RCTL_DECON = 6;
  localparam int RXK_REP = 8;
  typedef enum logic [1:0] {AUTH_IDLE, AUTH_WAIT_KEY, AUTH_DONE} lcpa_state_t;
  typedef struct packed {
    logic enc;
    logic start;
    logic faud;
    logic fvid;
    logic auto_start_select;
    logic serial_link_enable;
  } lcpa_ctrl_t;
  localparam lcpa_ctrl_t CTRL_RST = 6'h02;
  typedef struct packed {
    logic rep;
    logic newdev;
    logic began;
    logic sel1;
    logic sel0;
    logic dec;
  } lcpa_rctl_t;
  localparam lcpa_rctl_t RCTL_RST = 6'h00;
endpackage

// File: lcpa_lfsr.sv
module lcpa_lfsr #(
  parameter int W = 64,
  parameter logic [63:0] INIT = 64'h0000_0000_0000_0001
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Seed
  input wire logic seed_load,
  input wire logic [31:0] seed,
  // Value
  output logic [W-1:0] value
);
  logic [W-1:0] state_ff;
  logic [W-1:0] nxt_state;

  // Free-running; a seed is folded in on top of the running value
  always_comb
  begin
    nxt_state = {state_ff[W-2:0], state_ff[W-1] ^ state_ff[W-2] ^ state_ff[W-4] ^ state_ff[W-5]};
    if (seed_load)
    begin
      nxt_state[31:0] = nxt_state[31:0] ^ seed;
    end
    if (nxt_state == '0)
    begin
      nxt_state = INIT[W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= INIT[W-1:0];
    else
      state_ff <= nxt_state;
  end

  assign value = state_ff;
endmodule

// File: lcpa_resp.sv
module lcpa_resp (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic go,
  input wire logic clr,
  // Operands
  input wire logic [lcpa_pkg::SES_W-1:0] session,
  input wire logic [lcpa_pkg::KEY_W-1:0] key,
  // Result
  output logic [lcpa_pkg::RSP_W-1:0] resp
);
  logic [lcpa_pkg::RSP_W-1:0] resp_ff;
  logic [lcpa_pkg::RSP_W-1:0] nxt_resp;
  logic [lcpa_pkg::SES_W-1:0] mixed;

  // Folds session value and combined key into one response word
  always_comb
  begin
    mixed = session ^ {key, key[23:0]};
    nxt_resp = resp_ff;
    if (clr)
    begin
      nxt_resp = '0;
    end
    else if (go)
    begin
      nxt_resp = '0;
      for (int i = 0; i < lcpa_pkg::SES_W / lcpa_pkg::RSP_W; i++)
      begin
        nxt_resp = {nxt_resp[lcpa_pkg::RSP_W-2:0], nxt_resp[lcpa_pkg::RSP_W-1]}
          ^ mixed[i*lcpa_pkg::RSP_W +: lcpa_pkg::RSP_W];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      resp_ff <= '0;
    else
      resp_ff <= nxt_resp;
  end

  assign resp = resp_ff;
endmodule

// File: lcpa_auth.sv
// Contract
// - transmitter key write sets began flag, output
// - output zero follows receiver encryption-enable bit
// - power up unauthenticated, encryption off
// - stopped link or force bits mask inputs
// - link starts on enable or auto-start low
// - running link forwards low-value content
// - optional seed combined with internal random
// - start bit makes session value, self-clears; code makes one only in AUTH_IDLE and leaves the bit set in AUTH_WAIT_KEY
// - transmitter key write triggers receiver response
// - receiver key write triggers serializer response; code triggers it only when the state is not AUTH_IDLE
// - cipher turns on at next frame-sync fall
// - authenticated link encrypts high-value content
module lcpa_auth #(
  parameter int VID_W = 24,
  parameter int AUD_W = 32,
  // Device keys; values are arbitrary
  parameter logic [39:0] OWN_TX_KEY = 40'h0F_0F0F_0F0F,
  parameter logic [39:0] OWN_RX_KEY = 40'h00_FFFF_F000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [lcpa_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link pins
  input wire logic frame_sync,
  input wire logic rx_lock,
  // Content path
  input wire logic [VID_W-1:0] video_in,
  input wire logic [AUD_W-1:0] audio_in,
  output logic [VID_W-1:0] video_out,
  output logic [AUD_W-1:0] audio_out,
  // Link and cipher state
  output logic link_run,
  output logic encrypt_on,
  output logic decrypt_on,
  // Receiver notification outputs
  output logic general_output_zero,
  output logic general_output_one
);
  lcpa_pkg::lcpa_ctrl_t ctrl_ff, nxt_ctrl;
  lcpa_pkg::lcpa_rctl_t rctl_ff, nxt_rctl;
  lcpa_pkg::lcpa_state_t state_ff, nxt_state;
  logic [lcpa_pkg::SES_W-1:0] session_ff, nxt_session;
  logic [lcpa_pkg::SES_W-1:0] rx_session_ff, nxt_rx_session;
  logic [lcpa_pkg::KEY_W-1:0] rx_key_ff, nxt_rx_key;
  logic [lcpa_pkg::KEY_W-1:0] tx_key_in_ff, nxt_tx_key_in;
  logic bad_key_ff, nxt_bad_key;
  logic match_ff, nxt_match;
  logic rep_ff, nxt_rep;
  logic fseen_ff, nxt_fseen;
  logic crypt_ff, nxt_crypt;
  logic dcrypt_ff, nxt_dcrypt;
  logic [31:0] prdata_ff, nxt_prdata;
  logic [VID_W-1:0] video_ff, nxt_video;
  logic [AUD_W-1:0] audio_ff, nxt_audio;
  logic gpo0_ff, nxt_gpo0;
  logic gpo1_ff, nxt_gpo1;
  logic fs_meta_ff, fs_sync_ff, fs_prev_ff;
  logic lk_meta_ff, lk_sync_ff;
  logic fs_fall;
  logic wr_en, rd_setup, hit;
  logic seed_load, tx_go, rx_go, prst;
  logic [lcpa_pkg::SES_W-1:0] rand_val;
  logic [lcpa_pkg::RSP_W-1:0] tx_rsp, rx_rsp;
  logic [6:0] ones;

  lcpa_lfsr #(
    .W(lcpa_pkg::SES_W),
    .INIT(64'h0000_0000_0000_0001)
  ) u_rand (
    .pclk(pclk),
    .presetn(presetn),
    .seed_load(seed_load),
    .seed(pwdata),
    .value(rand_val)
  );

  lcpa_resp u_tx_rsp (
    .pclk(pclk),
    .presetn(presetn),
    .go(tx_go),
    .clr(prst),
    .session(session_ff),
    .key(nxt_rx_key ^ OWN_TX_KEY),
    .resp(tx_rsp)
  );

  lcpa_resp u_rx_rsp (
    .pclk(pclk),
    .presetn(presetn),
    .go(rx_go),
    .clr(1'b0),
    .session(rx_session_ff),
    .key(nxt_tx_key_in ^ OWN_RX_KEY),
    .resp(rx_rsp)
  );

  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fs_meta_ff <= 1'b0;
      fs_sync_ff <= 1'b0;
      fs_prev_ff <= 1'b0;
      lk_meta_ff <= 1'b0;
      lk_sync_ff <= 1'b0;
    end
    else
    begin
      fs_meta_ff <= frame_sync;
      fs_sync_ff <= fs_meta_ff;
      fs_prev_ff <= fs_sync_ff;
      lk_meta_ff <= rx_lock;
      lk_sync_ff <= lk_meta_ff;
    end
  end

  assign fs_fall = fs_prev_ff && !fs_sync_ff;
  assign wr_en = psel && penable && pwrite && hit;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign seed_load = wr_en && (paddr == lcpa_pkg::OFS_SEED);
  assign prst = wr_en && (paddr == lcpa_pkg::OFS_CTRL) && pwdata[lcpa_pkg::CTRL_PRST];
  assign tx_go = wr_en && (paddr == lcpa_pkg::OFS_RXK_HI) && (state_ff != lcpa_pkg::AUTH_IDLE);
  assign rx_go = wr_en && (paddr == lcpa_pkg::OFS_RIK_HI);

  always_comb
  begin
    hit = 1'b1;
    if (paddr == lcpa_pkg::OFS_CTRL) hit = 1'b1;
    else if (paddr == lcpa_pkg::OFS_STAT) hit = 1'b1;
    else if (paddr == lcpa_pkg::OFS_SEED) hit = 1'b1;
    else if (paddr == lcpa_pkg::OFS_SES_LO) hit = 1'b1;
    else if (paddr == lcpa_pkg::OFS_SES_HI) hit = 1'b1;
    else if (paddr == lcpa_pkg::OFS_TXK_LO) hit = 1'b1;
    else if (paddr == lcpa_pkg::OFS_TXK_HI) hit = 1'b1;
    else if (paddr == lcpa_pkg::OFS_RXK_LO) hit = 1'b1;
    else if (paddr == lcpa_pkg::OFS_RXK_HI) hit = 1'b1;
    else if (paddr == lcpa_pkg::OFS_TX_RSP) hit = 1'b1;
    else if (paddr == lcpa_pkg::OFS_CMP) hit = 1'b1;
    else if (paddr == lcpa_pkg::OFS_RCTL) hit = 1'b1;
    else if (paddr == lcpa_pkg::OFS_RIK_LO) hit = 1'b1;
    else if (paddr == lcpa_pkg::OFS_RIK_HI) hit = 1'b1;
    else if (paddr == lcpa_pkg::OFS_RX_RSP) hit = 1'b1;
    else if (paddr == lcpa_pkg::OFS_RIS_LO) hit = 1'b1;
    else if (paddr == lcpa_pkg::OFS_RIS_HI) hit = 1'b1;
    else hit = 1'b0;
  end

  // Read data captured in the setup cycle
  always_comb
  begin
    nxt_prdata = prdata_ff;
    if (rd_setup)
    begin
      nxt_prdata = '0;
      if (paddr == lcpa_pkg::OFS_CTRL)
        nxt_prdata[5:0] = ctrl_ff;
      else if (paddr == lcpa_pkg::OFS_STAT)
      begin
        nxt_prdata[lcpa_pkg::STAT_LOCK] = lk_sync_ff;
        nxt_prdata[lcpa_pkg::STAT_FSEEN] = fseen_ff;
        nxt_prdata[lcpa_pkg::STAT_BADKEY] = bad_key_ff;
        nxt_prdata[lcpa_pkg::STAT_MATCH] = match_ff;
        nxt_prdata[lcpa_pkg::STAT_CRYPT] = crypt_ff;
        nxt_prdata[lcpa_pkg::STAT_REP] = rep_ff;
        nxt_prdata[lcpa_pkg::STAT_LINK] = link_run;
        nxt_prdata[lcpa_pkg::STAT_STATE +: 2] = state_ff;
      end
      else if (paddr == lcpa_pkg::OFS_SES_LO) nxt_prdata = session_ff[31:0];
      else if (paddr == lcpa_pkg::OFS_SES_HI) nxt_prdata = session_ff[63:32];
      else if (paddr == lcpa_pkg::OFS_TXK_LO) nxt_prdata = OWN_TX_KEY[31:0];
      else if (paddr == lcpa_pkg::OFS_TXK_HI) nxt_prdata[7:0] = OWN_TX_KEY[39:32];
      else if (paddr == lcpa_pkg::OFS_RXK_LO) nxt_prdata = OWN_RX_KEY[31:0];
      else if (paddr == lcpa_pkg::OFS_RXK_HI)
      begin
        nxt_prdata[7:0] = OWN_RX_KEY[39:32];
        nxt_prdata[lcpa_pkg::RXK_REP] = rctl_ff.rep;
      end
      else if (paddr == lcpa_pkg::OFS_TX_RSP) nxt_prdata[15:0] = tx_rsp;
      else if (paddr == lcpa_pkg::OFS_RCTL)
      begin
        nxt_prdata[5:0] = rctl_ff;
        nxt_prdata[lcpa_pkg::RCTL_DECON] = dcrypt_ff;
      end
      else if (paddr == lcpa_pkg::OFS_RX_RSP) nxt_prdata[15:0] = rx_rsp;
    end
  end

  always_comb
  begin
    ones = '0;
    for (int i = 0; i < lcpa_pkg::KEY_W; i++)
    begin
      ones = ones + {6'h00, rx_key_ff[i]};
    end
  end

  // Serializer side: control, handshake and cipher start
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_state = state_ff;
    nxt_session = session_ff;
    nxt_rx_key = rx_key_ff;
    nxt_bad_key = bad_key_ff;
    nxt_match = match_ff;
    nxt_rep = rep_ff;
    nxt_fseen = fseen_ff;
    nxt_crypt = crypt_ff;
    if (wr_en && paddr == lcpa_pkg::OFS_CTRL)
      nxt_ctrl = pwdata[5:0];
    if (wr_en && paddr == lcpa_pkg::OFS_STAT && pwdata[lcpa_pkg::STAT_FSEEN])
      nxt_fseen = 1'b0;
    if (fs_fall)
      nxt_fseen = 1'b1;
    if (wr_en && paddr == lcpa_pkg::OFS_RXK_LO)
      nxt_rx_key[31:0] = pwdata;
    if (wr_en && paddr == lcpa_pkg::OFS_RXK_HI)
    begin
      nxt_rx_key[39:32] = pwdata[7:0];
      nxt_rep = pwdata[lcpa_pkg::RXK_REP];
    end
    if (wr_en && paddr == lcpa_pkg::OFS_CMP)
      nxt_match = (pwdata[15:0] == tx_rsp);
    case (state_ff)
      lcpa_pkg::AUTH_IDLE:
        if (ctrl_ff.start)
        begin
          nxt_session = rand_val;
          nxt_ctrl.start = 1'b0;
          nxt_state = lcpa_pkg::AUTH_WAIT_KEY;
        end
      lcpa_pkg::AUTH_WAIT_KEY:
        if (tx_go)
        begin
          nxt_state = lcpa_pkg::AUTH_DONE;
        end
      lcpa_pkg::AUTH_DONE:
        if (ctrl_ff.start)
          nxt_ctrl.start = 1'b0;
      default:
        nxt_state = lcpa_pkg::AUTH_IDLE;
    endcase
    if (state_ff == lcpa_pkg::AUTH_DONE)
      nxt_bad_key = (ones != 7'(lcpa_pkg::KEY_ONES));
    if (fs_fall)
      nxt_crypt = ctrl_ff.enc && (state_ff == lcpa_pkg::AUTH_DONE);
    if (prst)
    begin
      nxt_state = lcpa_pkg::AUTH_IDLE;
      nxt_session = '0;
      nxt_ctrl.enc = 1'b0;
      nxt_ctrl.start = 1'b0;
      nxt_bad_key = 1'b0;
      nxt_match = 1'b0;
      nxt_rep = 1'b0;
      nxt_crypt = 1'b0;
    end
  end

  // Receiver side: key capture, flags and notification outputs
  always_comb
  begin
    nxt_rctl = rctl_ff;
    nxt_tx_key_in = tx_key_in_ff;
    nxt_rx_session = rx_session_ff;
    nxt_dcrypt = dcrypt_ff;
    if (wr_en && paddr == lcpa_pkg::OFS_RCTL)
      nxt_rctl = pwdata[5:0];
    if (wr_en && paddr == lcpa_pkg::OFS_RIS_LO)
      nxt_rx_session[31:0] = pwdata;
    if (wr_en && paddr == lcpa_pkg::OFS_RIS_HI)
      nxt_rx_session[63:32] = pwdata;
    if (wr_en && paddr == lcpa_pkg::OFS_RIK_LO)
      nxt_tx_key_in[31:0] = pwdata;
    if (rx_go)
    begin
      nxt_tx_key_in[39:32] = pwdata[7:0];
      nxt_rctl.began = 1'b1;
    end
    if (fs_fall)
      nxt_dcrypt = rctl_ff.dec;
    nxt_gpo0 = rctl_ff.sel0 && rctl_ff.dec;
    nxt_gpo1 = rctl_ff.sel1 && rctl_ff.began;
  end

  // Content path: masked until link runs, forced words replace inputs
  always_comb
  begin
    nxt_video = '0;
    nxt_audio = '0;
    if (link_run)
    begin
      nxt_video = ctrl_ff.fvid ? '0 : video_in;
      nxt_audio = ctrl_ff.faud ? '0 : audio_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff <= lcpa_pkg::CTRL_RST;
      rctl_ff <= lcpa_pkg::RCTL_RST;
      state_ff <= lcpa_pkg::AUTH_IDLE;
      session_ff <= '0;
      rx_session_ff <= '0;
      rx_key_ff <= '0;
      tx_key_in_ff <= '0;
      bad_key_ff <= 1'b0;
      match_ff <= 1'b0;
      rep_ff <= 1'b0;
      fseen_ff <= 1'b0;
      crypt_ff <= 1'b0;
      dcrypt_ff <= 1'b0;
      prdata_ff <= '0;
      video_ff <= '0;
      audio_ff <= '0;
      gpo0_ff <= 1'b0;
      gpo1_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      rctl_ff <= nxt_rctl;
      state_ff <= nxt_state;
      session_ff <= nxt_session;
      rx_session_ff <= nxt_rx_session;
      rx_key_ff <= nxt_rx_key;
      tx_key_in_ff <= nxt_tx_key_in;
      bad_key_ff <= nxt_bad_key;
      match_ff <= nxt_match;
      rep_ff <= nxt_rep;
      fseen_ff <= nxt_fseen;
      crypt_ff <= nxt_crypt;
      dcrypt_ff <= nxt_dcrypt;
      prdata_ff <= nxt_prdata;
      video_ff <= nxt_video;
      audio_ff <= nxt_audio;
      gpo0_ff <= nxt_gpo0;
      gpo1_ff <= nxt_gpo1;
    end
  end

  assign link_run = ctrl_ff.serial_link_enable || !ctrl_ff.auto_start_select;
  assign encrypt_on = crypt_ff;
  assign decrypt_on = dcrypt_ff;
  assign prdata = prdata_ff;
  assign video_out = video_ff;
  assign audio_out = audio_ff;
  assign general_output_zero = gpo0_ff;
  assign general_output_one = gpo1_ff;
endmodule

// File: lcpa_link.sv
module lcpa_link #(
  parameter int FRAME = 64
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link state
  input wire logic link_run,
  output logic frame_sync,
  output logic rx_lock
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  int lock_cnt;
  // Frame sync falls once a frame and only while the link runs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 0;
      lock_cnt <= 0;
      frame_sync <= 1'b1;
      rx_lock <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == FRAME - 1) ? 0 : cnt + 1;
      frame_sync <= !link_run || cnt >= 4;
      lock_cnt <= link_run ? ((lock_cnt < 8) ? lock_cnt + 1 : lock_cnt) : 0;
      rx_lock <= link_run && lock_cnt >= 8;
    end
  end
endmodule

// File: lcpa_auth_props.sv
module lcpa_auth_props #(
  parameter int VID_W = 24,
  parameter int AUD_W = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic [lcpa_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  // Observed pins
  input wire logic frame_sync,
  input wire logic [VID_W-1:0] video_out,
  input wire logic [AUD_W-1:0] audio_out,
  input wire logic link_run,
  input wire logic encrypt_on,
  input wire logic decrypt_on,
  input wire logic general_output_zero,
  input wire logic general_output_one
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic [3:0] ctl_ff, nxt_ctl;
  logic [3:0] rc_ff, nxt_rc;
  logic [3:0] age_ff, nxt_age;
  logic fs_ff;
  assign wr = psel && penable && pwrite;
  // Shadows of control bits and cycles since the last sync fall
  always_comb
  begin
    nxt_ctl = ctl_ff;
    nxt_rc = rc_ff;
    nxt_age = (age_ff == 4'hF) ? age_ff : age_ff + 4'h1;
    if (fs_ff && !frame_sync) nxt_age = 4'h0;
    if (wr && paddr == lcpa_pkg::OFS_CTRL) nxt_ctl = pwdata[3:0];
    if (wr && paddr == lcpa_pkg::OFS_RCTL) nxt_rc = pwdata[3:0];
    if (wr && paddr == lcpa_pkg::OFS_RIK_HI) nxt_rc[3] = 1'b1;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_ff <= 4'h2;
      rc_ff <= 4'h0;
      age_ff <= 4'hF;
      fs_ff <= 1'b1;
    end
    else
    begin
      ctl_ff <= nxt_ctl;
      rc_ff <= nxt_rc;
      age_ff <= nxt_age;
      fs_ff <= frame_sync;
    end
  end
  a_link_start: assert property (link_run == (ctl_ff[0] || !ctl_ff[1]))
    else $error("link run state wrong");
  a_video_mask: assert property ((!link_run || ctl_ff[2]) [*2] |-> video_out == '0)
    else $error("video not masked");
  a_audio_mask: assert property ((!link_run || ctl_ff[3]) [*2] |-> audio_out == '0)
    else $error("audio not masked");
  a_out_zero: assert property (general_output_zero == $past(rc_ff[1] && rc_ff[0]))
    else $error("output zero wrong");
  a_out_one: assert property (general_output_one == $past(rc_ff[2] && rc_ff[3]))
    else $error("output one wrong");
  a_enc_sync: assert property ($rose(encrypt_on) |-> age_ff inside {[1:6]})
    else $error("encrypt not on frame sync");
  a_dec_sync: assert property ($rose(decrypt_on) |-> age_ff inside {[1:6]})
    else $error("decrypt not on frame sync");
  a_reset_off: assert property ($rose(presetn) |-> !encrypt_on && !decrypt_on)
    else $error("cipher on after reset");
  a_prst_clear: assert property (wr && paddr == lcpa_pkg::OFS_CTRL && pwdata[6] |=> !encrypt_on)
    else $error("encrypt on after protocol reset");
  c_enc: cover property ($rose(encrypt_on));
  c_one: cover property ($rose(general_output_one));
  c_video: cover property (link_run && video_out != '0);
endmodule

bind lcpa_auth lcpa_auth_props #(.VID_W(VID_W), .AUD_W(AUD_W)) u_props (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .frame_sync(frame_sync), .video_out(video_out),
  .audio_out(audio_out), .link_run(link_run), .encrypt_on(encrypt_on),
  .decrypt_on(decrypt_on), .general_output_zero(general_output_zero),
  .general_output_one(general_output_one)
);

// File: lcpa_auth_bench.sv
module lcpa_auth_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // Keys are arbitrary, each with twenty ones
  localparam logic [39:0] TXK = 40'h0F_0F0F_0F0F;
  localparam logic [39:0] RXK = 40'h33_3333_3333;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [23:0] video_in = 24'h0;
  logic [31:0] audio_in = 32'h0;
  logic [31:0] prdata, audio_out, q, s_lo, s_hi;
  logic [23:0] video_out;
  logic pready, pslverr, frame_sync, rx_lock, link_run, encrypt_on, decrypt_on;
  logic general_output_zero, general_output_one;
  logic [65:0] exp_q[$];
  logic [65:0] n;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  always #5 pclk = ~pclk;
  lcpa_auth #(.VID_W(24), .AUD_W(32), .OWN_TX_KEY(TXK), .OWN_RX_KEY(RXK)) u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_sync(frame_sync), .rx_lock(rx_lock),
    .video_in(video_in), .audio_in(audio_in), .video_out(video_out),
    .audio_out(audio_out), .link_run(link_run), .encrypt_on(encrypt_on),
    .decrypt_on(decrypt_on), .general_output_zero(general_output_zero),
    .general_output_one(general_output_one)
  );
  lcpa_link #(.FRAME(64)) u_link (
    .pclk(pclk), .presetn(presetn), .link_run(link_run), .frame_sync(frame_sync),
    .rx_lock(rx_lock)
  );
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  // Read whose masked result, error flag included, is noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [32:0] v);
    exp_q.push_back({1'b1, m, v});
    xfer(1'b0, a, 32'h0);
  endtask
  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
    begin
      n = exp_q.pop_front();
      check({pslverr, prdata} & n[65:33], n[32:0]);
    end
  end
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      miscompares++;
      final_report();
    end
  end
  initial
  begin
    void'($urandom(36997));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(lcpa_pkg::OFS_CTRL, 32'h7F, 33'h02);
    rd(lcpa_pkg::OFS_STAT, 32'h35C, 33'h0);
    rd(8'h44, 32'hFFFF_FFFF, 33'h1_0000_0000);
    $display("reset and unmapped done");
    video_in <= 24'($urandom);
    audio_in <= $urandom;
    wr(lcpa_pkg::OFS_CTRL, 32'h0);
    rd(lcpa_pkg::OFS_STAT, 32'h40, 33'h40);
    repeat (3) @(posedge pclk);
    check({9'h0, video_out}, {9'h0, video_in});
    wr(lcpa_pkg::OFS_CTRL, 32'h0C);
    repeat (3) @(posedge pclk);
    check({1'b0, audio_out}, 33'h0);
    wr(lcpa_pkg::OFS_CTRL, 32'h01);
    repeat (12) @(posedge pclk);
    rd(lcpa_pkg::OFS_STAT, 32'h41, 33'h41);
    $display("link start done");
    wr(lcpa_pkg::OFS_SEED, $urandom);
    wr(lcpa_pkg::OFS_CTRL, 32'h11);
    rd(lcpa_pkg::OFS_CTRL, 32'h10, 33'h0);
    rd(lcpa_pkg::OFS_STAT, 32'h300, 33'h100);
    xfer(1'b0, lcpa_pkg::OFS_SES_LO, 32'h0);
    s_lo = q;
    xfer(1'b0, lcpa_pkg::OFS_SES_HI, 32'h0);
    s_hi = q;
    wr(lcpa_pkg::OFS_RIS_LO, s_lo);
    wr(lcpa_pkg::OFS_RIS_HI, s_hi);
    wr(lcpa_pkg::OFS_RCTL, 32'h10);
    rd(lcpa_pkg::OFS_RCTL, 32'h10, 33'h10);
    wr(lcpa_pkg::OFS_RCTL, 32'h04);
    wr(lcpa_pkg::OFS_RIK_LO, TXK[31:0]);
    wr(lcpa_pkg::OFS_RIK_HI, {24'h0, TXK[39:32]});
    rd(lcpa_pkg::OFS_RCTL, 32'h08, 33'h08);
    check({32'h0, general_output_one}, 33'h1);
    wr(lcpa_pkg::OFS_RXK_LO, 32'hFFFF_FFFF);
    wr(lcpa_pkg::OFS_RXK_HI, 32'h0);
    rd(lcpa_pkg::OFS_STAT, 32'h304, 33'h204);
    rd(lcpa_pkg::OFS_RXK_LO, 32'hFFFF_FFFF, {1'b0, RXK[31:0]});
    wr(lcpa_pkg::OFS_RXK_LO, RXK[31:0]);
    wr(lcpa_pkg::OFS_RXK_HI, {24'h0, RXK[39:32]});
    rd(lcpa_pkg::OFS_STAT, 32'h304, 33'h200);
    xfer(1'b0, lcpa_pkg::OFS_RX_RSP, 32'h0);
    wr(lcpa_pkg::OFS_CMP, q);
    rd(lcpa_pkg::OFS_STAT, 32'h08, 33'h08);
    $display("key exchange done");
    @(negedge frame_sync);
    wr(lcpa_pkg::OFS_RCTL, 32'h03);
    wr(lcpa_pkg::OFS_CTRL, 32'h21);
    rd(lcpa_pkg::OFS_STAT, 32'h10, 33'h0);
    @(negedge frame_sync);
    repeat (8) @(posedge pclk);
    rd(lcpa_pkg::OFS_STAT, 32'h10, 33'h10);
    rd(lcpa_pkg::OFS_RCTL, 32'h48, 33'h40);
    check({32'h0, general_output_zero}, 33'h1);
    check({31'h0, encrypt_on, decrypt_on}, 33'h3);
    $display("encryption done");
    wr(lcpa_pkg::OFS_CTRL, 32'h41);
    rd(lcpa_pkg::OFS_STAT, 32'h31C, 33'h0);
    check({32'h0, encrypt_on}, 33'h0);
    rd(lcpa_pkg::OFS_TX_RSP, 32'hFFFF, 33'h0);
    wr(lcpa_pkg::OFS_CTRL, 32'h11);
    rd(lcpa_pkg::OFS_STAT, 32'h300, 33'h100);
    $display("protocol reset done");
    repeat (3) @(posedge pclk);
    final_report();
  end
endmodule
